// File: hdl/bsc_pkg.sv
// Summary of operation
// - indirect call: PC low from Z, upper cleared
// - extended call: PC upper from extended register
// - compare-skip on equal operands, flags untouched
// - compare immediate updates six flags, one cycle
// - skip when register bit is zero
// - skip when register bit is one
// - skip when I/O bit is zero
// - skip when I/O bit is one
// - branch when chosen status bit set
// - branch when chosen status bit clear
// - carry-clear branch, flags unchanged
// - unsigned same-or-higher equals carry-clear
// - signed ge branch when N xor V zero
// - signed lt branch when N xor V one
// - half-carry branches, set and clear forms
// - T flag branches, set and clear forms
// - overflow branches, set and clear forms
// - interrupt-enable branches, enabled and disabled
package bsc_pkg;

   // ********************************************************
   // widths
   // ********************************************************
   localparam int PC_W = 22;
   localparam int PC_LOW_W = 16;
   localparam int PC_HIGH_W = 6;
   localparam int DATA_W = 8;
   localparam int IO_ADDR_W = 5;
   localparam int BIT_SEL_W = 3;
   localparam int OFFS_W = 7;
   localparam int CNT_W = 3;

   // ********************************************************
   // status flag positions
   // ********************************************************
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   // ********************************************************
   // cycle counts and program counter steps
   // ********************************************************
   localparam logic [CNT_W-1:0] CYC_INDIRECT_CALL_NARROW = 3'h2;
   localparam logic [CNT_W-1:0] CYC_INDIRECT_CALL_WIDE = 3'h3;
   localparam logic [CNT_W-1:0] CYC_EXTENDED_INDIRECT_CALL = 3'h3;
   localparam logic [CNT_W-1:0] CYC_CMP_IMM = 3'h1;
   localparam logic [CNT_W-1:0] CYC_BASE = 3'h1;
   localparam logic [CNT_W-1:0] CYC_IO_BASE = 3'h2;
   localparam logic [CNT_W-1:0] CYC_BR_TAKEN = 3'h2;
   localparam logic [PC_W-1:0] PC_STEP_NEXT = 22'h000001;
   localparam logic [PC_W-1:0] PC_SKIP_ONE = 22'h000002;
   localparam logic [PC_W-1:0] PC_SKIP_TWO = 22'h000003;
   localparam logic [PC_W-1:0] PC_RESET = 22'h000000;
   localparam logic [PC_HIGH_W-1:0] PC_HIGH_CLEAR = 6'h00;
   localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
   localparam logic [IO_ADDR_W-1:0] IO_ADDR_RESET = 5'h00;

   // ********************************************************
   // operations
   // ********************************************************
   typedef enum logic [4:0] {
      OP_INDIRECT_CALL,
      OP_EXTENDED_INDIRECT_CALL,
      OP_COMPARE_SKIP_EQUAL,
      OP_COMPARE_IMMEDIATE,
      OP_SKIP_REG_BIT_CLEAR,
      OP_SKIP_REG_BIT_SET,
      OP_SKIP_IO_BIT_CLEAR,
      OP_SKIP_IO_BIT_SET,
      OP_BRANCH_STATUS_SET,
      OP_BRANCH_STATUS_CLEAR,
      OP_BRANCH_CARRY_CLEAR,
      OP_BRANCH_UNSIGNED_GE,
      OP_BRANCH_SIGNED_GE,
      OP_BRANCH_SIGNED_LT,
      OP_BRANCH_HALFCARRY_SET,
      OP_BRANCH_HALFCARRY_CLEAR,
      OP_BRANCH_TFLAG_SET,
      OP_BRANCH_TFLAG_CLEAR,
      OP_BRANCH_OVERFLOW_SET,
      OP_BRANCH_OVERFLOW_CLEAR,
      OP_BRANCH_IRQ_ENABLED,
      OP_BRANCH_IRQ_DISABLED
   } bsc_op_t;

   typedef struct packed {
      bsc_op_t op;
      logic [DATA_W-1:0] rd;
      logic [DATA_W-1:0] rr;
      logic [DATA_W-1:0] imm;
      logic [BIT_SEL_W-1:0] bitSel;
      logic [IO_ADDR_W-1:0] ioAddr;
      logic [OFFS_W-1:0] offset;
      logic [PC_W-1:0] pc;
      logic [PC_LOW_W-1:0] zPtr;
      logic [PC_HIGH_W-1:0] extendedIndirectReg;
      logic [DATA_W-1:0] statusFlagsReg;
      logic nextTwoWord;
   } bsc_req_t;

   typedef struct packed {
      logic [PC_W-1:0] pcNext;
      logic [PC_W-1:0] returnAddr;
      logic pushReturn;
      logic [DATA_W-1:0] flags;
      logic flagsWe;
      logic taken;
      logic [CNT_W-1:0] cycles;
   } bsc_res_t;

endpackage

// File: hdl/bsc_compare.sv
`timescale 1ns/1ps
`default_nettype none
module bsc_compare
(
   input wire logic [bsc_pkg::DATA_W-1:0] lhs,
   input wire logic [bsc_pkg::DATA_W-1:0] rhs,
   input wire logic [bsc_pkg::DATA_W-1:0] flagsIn,
   output logic [bsc_pkg::DATA_W-1:0] flagsOut
);
   import bsc_pkg::*;

   logic [DATA_W-1:0] diff;
   logic carry;
   logic half;
   logic ovf;

   // ********************************************************
   // subtract without writeback
   // ********************************************************
   always_comb
   begin
      diff = lhs - rhs;
      carry = (~lhs[7] & rhs[7]) | (rhs[7] & diff[7]) | (diff[7] & ~lhs[7]);
      half = (~lhs[3] & rhs[3]) | (rhs[3] & diff[3]) | (diff[3] & ~lhs[3]);
      ovf = (lhs[7] & ~rhs[7] & ~diff[7]) | (~lhs[7] & rhs[7] & diff[7]);
      flagsOut = flagsIn;
      flagsOut[FLAG_C] = carry;
      flagsOut[FLAG_Z] = (diff == 8'h00);
      flagsOut[FLAG_N] = diff[7];
      flagsOut[FLAG_V] = ovf;
      flagsOut[FLAG_S] = diff[7] ^ ovf;
      flagsOut[FLAG_H] = half;
   end

endmodule // bsc_compare
`default_nettype wire

// File: hdl/branch_skip_call_unit.sv
`timescale 1ns/1ps
`default_nettype none
module branch_skip_call_unit
#(
   parameter bit WIDE_PC = 1'b1
)
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic start,
   input wire bsc_pkg::bsc_req_t req,
   input wire logic [bsc_pkg::DATA_W-1:0] ioRdData,
   output logic ready,
   output logic done,
   output bsc_pkg::bsc_res_t res,
   output logic ioRdEn,
   output logic [bsc_pkg::IO_ADDR_W-1:0] ioAddr
);
   import bsc_pkg::*;

   // ********************************************************
   // declarations
   // ********************************************************
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_IO_REQ,
      ST_IO_DATA,
      ST_EXEC
   } bsc_state_t;

   bsc_state_t state_q;
   bsc_state_t state_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic done_q;
   logic ioRdEn_q;
   logic [IO_ADDR_W-1:0] ioAddr_q;
   bsc_res_t res_q;
   bsc_res_t res_d;
   bsc_req_t held_q;
   logic accept;
   logic [DATA_W-1:0] cmpFlags;
   logic [PC_W-1:0] pcPlusOne;
   logic [PC_W-1:0] pcSkip;
   logic [PC_W-1:0] pcBranch;
   logic [PC_W-1:0] heldPcPlusOne;
   logic [PC_W-1:0] heldPcSkip;
   logic [CNT_W-1:0] skipCycles;
   logic [CNT_W-1:0] heldSkipCycles;
   logic brCond;
   logic isBranch;
   logic skipCond;
   logic ioBit;
   logic ioSkip;

   assign accept = start && (state_q == ST_IDLE);
   assign ready = (state_q == ST_IDLE);
   assign done = done_q;
   assign res = res_q;
   assign ioRdEn = ioRdEn_q;
   assign ioAddr = ioAddr_q;

   // ********************************************************
   // compare flags
   // ********************************************************
   bsc_compare u_compare
   (
      .lhs(req.rd),
      .rhs(req.imm),
      .flagsIn(req.statusFlagsReg),
      .flagsOut(cmpFlags)
   );

   // ********************************************************
   // program counter targets
   // ********************************************************
   always_comb
   begin
      pcPlusOne = req.pc + PC_STEP_NEXT;
      pcBranch = req.pc + {{(PC_W-OFFS_W){req.offset[OFFS_W-1]}},
                           req.offset} + PC_STEP_NEXT;
      // skipped instruction length picks two or three words
      if (req.nextTwoWord)
      begin
         pcSkip = req.pc + PC_SKIP_TWO;
         skipCycles = 3'h2;
      end
      else
      begin
         pcSkip = req.pc + PC_SKIP_ONE;
         skipCycles = 3'h1;
      end
   end

   always_comb
   begin
      heldPcPlusOne = held_q.pc + PC_STEP_NEXT;
      if (held_q.nextTwoWord)
      begin
         heldPcSkip = held_q.pc + PC_SKIP_TWO;
         heldSkipCycles = 3'h2;
      end
      else
      begin
         heldPcSkip = held_q.pc + PC_SKIP_ONE;
         heldSkipCycles = 3'h1;
      end
   end

   // ********************************************************
   // branch and skip conditions
   // ********************************************************
   always_comb
   begin
      brCond = 1'b0;
      isBranch = 1'b1;
      case (req.op)
         OP_BRANCH_STATUS_SET:
            brCond = req.statusFlagsReg[req.bitSel];
         OP_BRANCH_STATUS_CLEAR:
            brCond = ~req.statusFlagsReg[req.bitSel];
         OP_BRANCH_CARRY_CLEAR:
            brCond = ~req.statusFlagsReg[FLAG_C];
         OP_BRANCH_UNSIGNED_GE:
            brCond = ~req.statusFlagsReg[FLAG_C];
         OP_BRANCH_SIGNED_GE:
            brCond = ~(req.statusFlagsReg[FLAG_N] ^
                       req.statusFlagsReg[FLAG_V]);
         OP_BRANCH_SIGNED_LT:
            brCond = req.statusFlagsReg[FLAG_N] ^
                     req.statusFlagsReg[FLAG_V];
         OP_BRANCH_HALFCARRY_SET:
            brCond = req.statusFlagsReg[FLAG_H];
         OP_BRANCH_HALFCARRY_CLEAR:
            brCond = ~req.statusFlagsReg[FLAG_H];
         OP_BRANCH_TFLAG_SET:
            brCond = req.statusFlagsReg[FLAG_T];
         OP_BRANCH_TFLAG_CLEAR:
            brCond = ~req.statusFlagsReg[FLAG_T];
         OP_BRANCH_OVERFLOW_SET:
            brCond = req.statusFlagsReg[FLAG_V];
         OP_BRANCH_OVERFLOW_CLEAR:
            brCond = ~req.statusFlagsReg[FLAG_V];
         OP_BRANCH_IRQ_ENABLED:
            brCond = req.statusFlagsReg[FLAG_I];
         OP_BRANCH_IRQ_DISABLED:
            brCond = ~req.statusFlagsReg[FLAG_I];
         default:
            isBranch = 1'b0;
      endcase
   end

   always_comb
   begin
      skipCond = 1'b0;
      case (req.op)
         OP_COMPARE_SKIP_EQUAL:
            skipCond = (req.rd == req.rr);
         OP_SKIP_REG_BIT_CLEAR:
            skipCond = ~req.rr[req.bitSel];
         OP_SKIP_REG_BIT_SET:
            skipCond = req.rr[req.bitSel];
         default:
            skipCond = 1'b0;
      endcase
   end

   // io bit sampled from the held request
   always_comb
   begin
      ioBit = ioRdData[held_q.bitSel];
      if (held_q.op == OP_SKIP_IO_BIT_SET)
      begin
         ioSkip = ioBit;
      end
      else
      begin
         ioSkip = ~ioBit;
      end
   end

   // ********************************************************
   // result at acceptance
   // ********************************************************
   always_comb
   begin
      res_d = res_q;
      res_d.pushReturn = 1'b0;
      res_d.flagsWe = 1'b0;
      res_d.taken = 1'b0;
      res_d.flags = req.statusFlagsReg;
      res_d.returnAddr = pcPlusOne;
      res_d.pcNext = pcPlusOne;
      res_d.cycles = CYC_BASE;
      case (req.op)
         OP_INDIRECT_CALL:
         begin
            res_d.pcNext = {PC_HIGH_CLEAR, req.zPtr};
            res_d.pushReturn = 1'b1;
            res_d.taken = 1'b1;
            res_d.cycles = WIDE_PC ? CYC_INDIRECT_CALL_WIDE : CYC_INDIRECT_CALL_NARROW;
         end
         OP_EXTENDED_INDIRECT_CALL:
         begin
            res_d.pcNext = {req.extendedIndirectReg, req.zPtr};
            res_d.pushReturn = 1'b1;
            res_d.taken = 1'b1;
            res_d.cycles = CYC_EXTENDED_INDIRECT_CALL;
         end
         OP_COMPARE_IMMEDIATE:
         begin
            res_d.flags = cmpFlags;
            res_d.flagsWe = 1'b1;
            res_d.cycles = CYC_CMP_IMM;
         end
         OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET:
         begin
            if (skipCond)
            begin
               res_d.pcNext = pcSkip;
               res_d.taken = 1'b1;
               res_d.cycles = CYC_BASE + skipCycles;
            end
         end
         default:
         begin
            if (isBranch && brCond)
            begin
               res_d.pcNext = pcBranch;
               res_d.taken = 1'b1;
               res_d.cycles = CYC_BR_TAKEN;
            end
         end
      endcase
   end

   // ********************************************************
   // sequencing
   // ********************************************************
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         ST_IDLE:
         begin
            if (accept)
            begin
               if (req.op == OP_SKIP_IO_BIT_CLEAR ||
                   req.op == OP_SKIP_IO_BIT_SET)
               begin
                  state_d = ST_IO_REQ;
               end
               else
               begin
                  state_d = ST_EXEC;
                  cnt_d = res_d.cycles - CYC_BASE;
               end
            end
         end
         ST_IO_REQ:
            state_d = ST_IO_DATA;
         ST_IO_DATA:
         begin
            if (ioSkip)
            begin
               state_d = ST_EXEC;
               cnt_d = heldSkipCycles - CYC_BASE;
            end
            else
            begin
               state_d = ST_IDLE;
            end
         end
         ST_EXEC:
         begin
            if (cnt_q == 3'h0)
            begin
               state_d = ST_IDLE;
            end
            else
            begin
               cnt_d = cnt_q - 3'h1;
            end
         end
         default:
            state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         state_q <= ST_IDLE;
         cnt_q <= 3'h0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // ********************************************************
   // request capture and io read strobe
   // ********************************************************
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         held_q <= '0;
      end
      else if (accept)
      begin
         held_q <= req;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         ioRdEn_q <= 1'b0;
         ioAddr_q <= IO_ADDR_RESET;
      end
      else
      begin
         ioRdEn_q <= accept && (state_d == ST_IO_REQ);
         if (accept)
         begin
            ioAddr_q <= req.ioAddr;
         end
      end
   end

   // ********************************************************
   // result and completion
   // ********************************************************
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         res_q <= '{pcNext: PC_RESET, returnAddr: PC_RESET,
                    pushReturn: 1'b0, flags: FLAGS_RESET,
                    flagsWe: 1'b0, taken: 1'b0, cycles: 3'h0};
      end
      else if (accept)
      begin
         res_q <= res_d;
      end
      else if (state_q == ST_IO_DATA)
      begin
         res_q.flags <= held_q.statusFlagsReg;
         res_q.flagsWe <= 1'b0;
         res_q.pushReturn <= 1'b0;
         res_q.returnAddr <= heldPcPlusOne;
         res_q.taken <= ioSkip;
         if (ioSkip)
         begin
            res_q.pcNext <= heldPcSkip;
            res_q.cycles <= CYC_IO_BASE + heldSkipCycles;
         end
         else
         begin
            res_q.pcNext <= heldPcPlusOne;
            res_q.cycles <= CYC_IO_BASE;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= ((state_q == ST_EXEC) && (cnt_q == 3'h0)) ||
                   ((state_q == ST_IO_DATA) && !ioSkip);
      end
   end

endmodule // branch_skip_call_unit
`default_nettype wire

// File: test/bsc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module bsc_monitor
#(
   parameter bit WIDE_PC = 1'b1
)
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic start,
   input wire bsc_pkg::bsc_req_t req,
   input wire logic [bsc_pkg::DATA_W-1:0] ioRdData,
   input wire logic ready,
   input wire logic done,
   input wire bsc_pkg::bsc_res_t res,
   input wire logic ioRdEn,
   input wire logic [bsc_pkg::IO_ADDR_W-1:0] ioAddr
);
   import bsc_pkg::*;
   // ********
   // helpers
   // ********
   wire logic acc = start && ready;
   wire logic [PC_W-1:0] brTgt = req.pc + {{15{req.offset[6]}}, req.offset}
      + PC_STEP_NEXT;
   wire logic isBr = req.op inside
      {[OP_BRANCH_STATUS_SET:OP_BRANCH_IRQ_DISABLED]};
   wire logic isIo = req.op inside {OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET};
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // ********
   // checks
   // ********
   property p_call;
      acc && req.op == OP_INDIRECT_CALL |=> res.pushReturn
         && res.pcNext == {PC_HIGH_CLEAR, $past(req.zPtr)}
         && res.cycles == (WIDE_PC ? 3'h3 : 3'h2);
   endproperty
   a_call: assert property (p_call) else $error("bad call");
   property p_ecall;
      acc && req.op == OP_EXTENDED_INDIRECT_CALL |=> res.cycles == 3'h3
         && res.pcNext == {$past(req.extendedIndirectReg), $past(req.zPtr)};
   endproperty
   a_ecall: assert property (p_ecall) else $error("bad ecall");
   property p_cmpimm;
      acc && req.op == OP_COMPARE_IMMEDIATE |=> res.flagsWe ##1 done;
   endproperty
   a_cmpimm: assert property (p_cmpimm) else $error("bad cmp");
   property p_keep;
      acc && !isIo && req.op != OP_COMPARE_IMMEDIATE |=> !res.flagsWe;
   endproperty
   a_keep: assert property (p_keep) else $error("flags wr");
   property p_branch;
      acc && isBr |=> res.cycles == (res.taken ? 3'h2 : 3'h1) && res.pcNext
         == (res.taken ? $past(brTgt) : $past(req.pc) + PC_STEP_NEXT);
   endproperty
   a_branch: assert property (p_branch) else $error("bad br");
   property p_carry;
      acc && req.op inside {OP_BRANCH_CARRY_CLEAR, OP_BRANCH_UNSIGNED_GE}
         |=> res.taken == !$past(req.statusFlagsReg[FLAG_C]);
   endproperty
   a_carry: assert property (p_carry) else $error("bad bcc");
   property p_signed;
      acc && req.op inside {OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT}
         |=> res.taken == ($past(req.statusFlagsReg[FLAG_N]
         ^ req.statusFlagsReg[FLAG_V]) ^ $past(req.op == OP_BRANCH_SIGNED_GE));
   endproperty
   a_signed: assert property (p_signed) else $error("bad sgn");
   property p_skip;
      acc && req.op inside {[OP_COMPARE_SKIP_EQUAL:OP_SKIP_REG_BIT_SET]}
         && req.op != OP_COMPARE_IMMEDIATE
         |=> res.pcNext == $past(req.pc) + PC_W'(res.cycles);
   endproperty
   a_skip: assert property (p_skip) else $error("bad skip");
   property p_regbit;
      acc && req.op inside {OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET}
         |=> (res.cycles != 3'h1) == ($past(req.rr[req.bitSel])
         ^ $past(req.op == OP_SKIP_REG_BIT_CLEAR));
   endproperty
   a_regbit: assert property (p_regbit) else $error("bad bit");
   property p_io;
      acc && isIo |=> ioRdEn && ioAddr == $past(req.ioAddr) && !ready
         ##1 !ioRdEn ##[1:3] done;
   endproperty
   a_io: assert property (p_io) else $error("bad io");
endmodule // bsc_monitor
bind branch_skip_call_unit bsc_monitor #(.WIDE_PC(WIDE_PC)) u_bsc_monitor
(
   .mclk(mclk),
   .reset(reset),
   .start(start),
   .req(req),
   .ioRdData(ioRdData),
   .ready(ready),
   .done(done),
   .res(res),
   .ioRdEn(ioRdEn),
   .ioAddr(ioAddr)
);
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import bsc_pkg::*;
   typedef struct packed {
      bsc_op_t op;
      logic [7:0] rd;
      logic [7:0] rr;
      logic [2:0] bs;
      logic two;
      logic [7:0] io;
      logic [21:0] pc;
      logic [2:0] cyc;
   } bsc_row_t;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic start = 1'b0;
   bsc_req_t req = '0;
   logic [7:0] ioRdData = 8'h00;
   logic [7:0] ioV = 8'h00;
   logic ready, done, ioRdEn, tk;
   bsc_res_t res;
   logic [IO_ADDR_W-1:0] ioAddr;
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;
   int n;
   logic [7:0] d, rd, im;
   bsc_row_t rows [14] = '{
      '{OP_INDIRECT_CALL, 8'h00, 8'h00, 3'h0, 1'b0, 8'h00, 22'h00ABCD, 3'h3},
      '{OP_EXTENDED_INDIRECT_CALL, 8'h00, 8'h00, 3'h0, 1'b0, 8'h00,
         22'h2AABCD, 3'h3},
      '{OP_COMPARE_SKIP_EQUAL, 8'h5A, 8'h5A, 3'h0, 1'b0, 8'h00, 22'h001002, 3'h2},
      '{OP_COMPARE_SKIP_EQUAL, 8'h5A, 8'h5A, 3'h0, 1'b1, 8'h00, 22'h001003, 3'h3},
      '{OP_COMPARE_SKIP_EQUAL, 8'h5A, 8'h5B, 3'h0, 1'b1, 8'h00, 22'h001001, 3'h1},
      '{OP_SKIP_REG_BIT_CLEAR, 8'h00, 8'hFE, 3'h0, 1'b0, 8'h00, 22'h001002, 3'h2},
      '{OP_SKIP_REG_BIT_CLEAR, 8'h00, 8'h80, 3'h7, 1'b0, 8'h00, 22'h001001, 3'h1},
      '{OP_SKIP_REG_BIT_SET, 8'h00, 8'h80, 3'h7, 1'b1, 8'h00, 22'h001003, 3'h3},
      '{OP_SKIP_REG_BIT_SET, 8'h00, 8'h7F, 3'h7, 1'b0, 8'h00, 22'h001001, 3'h1},
      '{OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'h00, 3'h3, 1'b1, 8'hF7, 22'h001003, 3'h4},
      '{OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'h00, 3'h3, 1'b0, 8'h08, 22'h001001, 3'h2},
      '{OP_SKIP_IO_BIT_SET, 8'h00, 8'h00, 3'h0, 1'b0, 8'h01, 22'h001002, 3'h3},
      '{OP_SKIP_IO_BIT_SET, 8'h00, 8'h00, 3'h0, 1'b1, 8'hFE, 22'h001001, 3'h2},
      '{OP_COMPARE_IMMEDIATE, 8'h33, 8'h00, 3'h0, 1'b0, 8'h00, 22'h001001, 3'h1}};
   logic [7:0] sregs [10] = '{8'h00, 8'hFF, 8'h01, 8'h04, 8'h08, 8'h0C, 8'h20,
      8'h40, 8'h80, 8'h55};
   logic [15:0] pairs [4] = '{16'h8001, 16'h1001, 16'h0505, 16'h0001};

   branch_skip_call_unit u_branch_skip_call_unit
   (
      .mclk(mclk),
      .reset(reset),
      .start(start),
      .req(req),
      .ioRdData(ioRdData),
      .ready(ready),
      .done(done),
      .res(res),
      .ioRdEn(ioRdEn),
      .ioAddr(ioAddr)
   );

   // ********
   // clock, I/O space, watchdog
   // ********
   initial forever #20 mclk = ~mclk;
   always @(posedge mclk) ioRdData <= ioRdEn ? ioV : ~ioV;
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         n_fail++;
         summarize();
      end
   end

   // ********
   // helpers
   // ********
   function automatic bsc_req_t mk(bsc_op_t op, logic [7:0] rd, rr, imm,
      logic [2:0] bs, logic [7:0] sr, logic two);
      return '{op:op, rd:rd, rr:rr, imm:imm, bitSel:bs, ioAddr:5'h1F,
         offset:7'h40, pc:22'h001000, zPtr:16'hABCD,
         extendedIndirectReg:6'h2A, statusFlagsReg:sr, nextTwoWord:two};
   endfunction
   function automatic logic cond(bsc_op_t op, logic [7:0] f, logic [2:0] b);
      case (op)
         OP_BRANCH_STATUS_SET: return f[b];
         OP_BRANCH_STATUS_CLEAR: return !f[b];
         OP_BRANCH_CARRY_CLEAR, OP_BRANCH_UNSIGNED_GE: return !f[FLAG_C];
         OP_BRANCH_SIGNED_GE: return !(f[FLAG_N] ^ f[FLAG_V]);
         OP_BRANCH_SIGNED_LT: return f[FLAG_N] ^ f[FLAG_V];
         OP_BRANCH_HALFCARRY_SET: return f[FLAG_H];
         OP_BRANCH_HALFCARRY_CLEAR: return !f[FLAG_H];
         OP_BRANCH_TFLAG_SET: return f[FLAG_T];
         OP_BRANCH_TFLAG_CLEAR: return !f[FLAG_T];
         OP_BRANCH_OVERFLOW_SET: return f[FLAG_V];
         OP_BRANCH_OVERFLOW_CLEAR: return !f[FLAG_V];
         OP_BRANCH_IRQ_ENABLED: return f[FLAG_I];
         default: return !f[FLAG_I];
      endcase
   endfunction
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // poke holds start one more cycle while busy, which must be ignored
   task automatic run(input bsc_req_t r, input logic poke, output int m);
      @(posedge mclk);
      start <= 1'b1;
      req <= r;
      @(posedge mclk);
      start <= poke;
      req.zPtr <= 16'h0000;
      if (poke) @(posedge mclk) start <= 1'b0;
      m = poke;
      do @(negedge mclk) m++; while (done !== 1'b1 && m < 20);
      m = m - 1;
   endtask
   task summarize;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ********
   // sequence
   // ********
   initial
   begin
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      chk(ready, 1'b1);
      chk({done, ioRdEn, ioAddr, res}, '0);
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      $display("test reset done");
      foreach (rows[i])
      begin
         ioV = rows[i].io;
         run(mk(rows[i].op, rows[i].rd, rows[i].rr, 8'h00, rows[i].bs, 8'h00,
            rows[i].two), i == 1, n);
         chk(res.pcNext, rows[i].pc);
         chk(res.cycles, rows[i].cyc);
         chk(n, rows[i].cyc);
         chk(res.flagsWe, rows[i].op == OP_COMPARE_IMMEDIATE);
         if (i > 8 && i < 13) chk(ioAddr, 5'h1F);
      end
      $display("test rows done");
      for (int o = int'(OP_BRANCH_STATUS_SET); o < 22; o++)
         for (int k = 0; k < 10; k++)
         begin
            tk = cond(bsc_op_t'(o), sregs[k], k[2:0]);
            run(mk(bsc_op_t'(o), 0, 0, 0, k[2:0], sregs[k], 0), 0, n);
            chk(res.taken, tk);
            chk(res.pcNext, tk ? 22'h000FC1 : 22'h001001);
            chk(n, tk ? 2 : 1);
         end
      $display("test branches done");
      foreach (pairs[i])
      begin
         {rd, im} = pairs[i];
         d = rd - im;
         run(mk(OP_COMPARE_IMMEDIATE, rd, 0, im, 0, 8'hC0, 0), 0, n);
         chk(res.flags, {2'b11, rd[3:0] < im[3:0], d[7] ^ (rd[7] != im[7]
            && d[7] != rd[7]), rd[7] != im[7] && d[7] != rd[7], d[7],
            d == 8'h00, rd < im});
         chk(n, 1);
      end
      $display("test compare done");
      @(posedge mclk);
      start <= 1'b1;
      req <= mk(OP_EXTENDED_INDIRECT_CALL, 0, 0, 0, 0, 0, 0);
      @(posedge mclk);
      start <= 1'b0;
      reset <= 1'b1;
      @(posedge mclk);
      reset <= 1'b0;
      @(negedge mclk);
      chk(ready, 1'b1);
      chk(res, '0);
      repeat (4) @(negedge mclk) chk(done, 1'b0);
      $display("test mid reset done");
      summarize();
   end
endmodule // tb_top
`default_nettype wire
